/* File: verilog/fifo_ctl_pkg.sv */
// shared constants and types for the handshake fifo controller
package fifo_ctl_pkg;
  // ==========================================================
  // word geometry
  localparam int WORD_W = 4;
  localparam int DEPTH = 64;
  // ==========================================================
  // timing: least time between handshake edges
  localparam int CLK_NS = 10;
  localparam int EDGE_GAP_NS = 50;
  localparam int EDGE_GAP_CYC = (EDGE_GAP_NS + CLK_NS - 1) / CLK_NS;
  // master clear low time, ns and cycles
  localparam int CLEAR_NS = 100;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // ==========================================================
  // handshake states, one-hot
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_RAISE = 4'b0010,
    HS_WAIT_ACK = 4'b0100,
    HS_LOWER = 4'b1000
  } hs_state_t;
endpackage

/* File: verilog/word_buf_if.sv */
// valid/ready stream carrier between controller and its buffer
`timescale 1ns/1ps
`default_nettype none
interface word_buf_if #(parameter int W = 4);
  logic valid; // word offered
  logic ready; // word accepted
  logic [W-1:0] data; // word itself
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: verilog/word_skid_buf.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_skid_buf #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // streams
  word_buf_if.dst in_s,
  word_buf_if.src out_s
);
  // ==========================================================
  // storage: two slots addressed by index
  logic [W-1:0] mem [2];
  logic wr_ptr; // next slot to write
  logic rd_ptr; // next slot to read
  logic [1:0] count; // words held
  logic do_wr;
  logic do_rd;
  assign do_wr = in_s.valid && in_s.ready;
  assign do_rd = out_s.valid && out_s.ready;
  // honest full and empty
  assign in_s.ready = (count != 2'd2);
  assign out_s.valid = (count != 2'd0);
  assign out_s.data = mem[rd_ptr];
  // write side
  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_s.data;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (do_wr) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_rd) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= 2'(count + {1'b0, do_wr} - {1'b0, do_rd});
    end
  end
endmodule
`default_nettype wire

/* File: verilog/fifo_host_ctl.sv */
// host controller driving a clockless handshake fifo through its pins
//
// Behaviour
// RULE_01: device input stage loads under handshake
// RULE_02: device output stage governed by handshake
// RULE_03: device moves middle words internally
// RULE_04: device keeps per-word valid flags
// RULE_05: empty fifo: word falls through
// RULE_06: full fifo read: vacancy bubbles back
// RULE_07: device holds 64 words, 4/5 bits
// RULE_08: devices chain for depth, no glue
// RULE_09: pulse master clear low once first
// RULE_10: device raises input ready when free
// RULE_11: rising shift-in with ready captures word
// RULE_12: device drops input ready on shift-in
// RULE_13: lower shift-in only after ready falls
// RULE_14: ready returns after shift-in falls, unless full
// RULE_15: captured word moves inward on fall
// RULE_16: output ready only with valid word
// RULE_17: raise shift-out while output ready
// RULE_18: output word stable while shift-out high
// RULE_19: next word and ready after shift-out falls
// RULE_20: empty: output ready stays low
// RULE_21: shift-in while not ready ignored
// RULE_22: next word moves on shift-out fall
// RULE_23: shift-out while not ready ignored
`timescale 1ns/1ps
`default_nettype none
module fifo_host_ctl
  import fifo_ctl_pkg::*;
#(
  parameter int WORD_WIDTH = WORD_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // producer side, user words to write
  input wire logic wr_valid_i,
  input wire logic [WORD_WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  // consumer side, words read back
  output logic rd_valid_o,
  output logic [WORD_WIDTH-1:0] rd_data_o,
  input wire logic rd_ready_i,
  // fifo input pins
  output logic master_clear_n_o,
  output logic shift_in_o,
  output logic [WORD_WIDTH-1:0] input_word_bus_o,
  input wire logic input_ready_flag_i,
  // fifo output pins
  output logic shift_out_o,
  input wire logic output_ready_flag_i,
  input wire logic [WORD_WIDTH-1:0] output_word_bus_i,
  // status
  output logic init_done_o
);
  // ==========================================================
  // pin synchronisers: first stage read only by second
  logic ir_s1, ir_s2;
  logic or_s1, or_s2;
  logic [WORD_WIDTH-1:0] ob_s1, ob_s2;
  always_ff @(posedge clk_i) begin
    ir_s1 <= input_ready_flag_i;
    ir_s2 <= ir_s1;
    or_s1 <= output_ready_flag_i;
    or_s2 <= or_s1;
    ob_s1 <= output_word_bus_i;
    ob_s2 <= ob_s1;
  end

  // ==========================================================
  // master clear pulse after reset
  logic [7:0] clr_cnt; // low time still to run
  logic init_done; // clear complete
  // RULE_09: one low clear pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_clear_n_o <= 1'b0;
      clr_cnt <= 8'(CLEAR_CYC);
      init_done <= 1'b0;
    end else if (clr_cnt != CNT_ZERO) begin
      clr_cnt <= clr_cnt - 8'd1;
    end else begin
      master_clear_n_o <= 1'b1;
      init_done <= 1'b1;
    end
  end
  assign init_done_o = init_done;

  // ==========================================================
  // write handshake: shift-in strobe
  hs_state_t wr_st; // write state
  logic [7:0] wr_gap; // spacing between edges
  logic wr_ready; // registered accept flag, drives the port directly
  logic next_wr_ready;
  // accept a user word only when idle with the device ready
  // the flag drops on the edge that takes a word, so no second word slips in
  assign next_wr_ready = init_done && (wr_st == HS_IDLE) && ir_s2 && (wr_gap == CNT_ZERO)
    && !(wr_valid_i && wr_ready);
  // accept flag register, one cycle behind the state but never early
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ready <= 1'b0;
    end else begin
      wr_ready <= next_wr_ready;
    end
  end
  assign wr_ready_o = wr_ready;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_st <= HS_IDLE;
      shift_in_o <= 1'b0;
      input_word_bus_o <= '0;
      wr_gap <= CNT_ZERO;
    end else begin
      if (wr_gap != CNT_ZERO) begin
        wr_gap <= wr_gap - 8'd1;
      end
      case (wr_st)
        HS_IDLE: begin
          // RULE_21: strobe only while input ready high
          if (wr_valid_i && wr_ready) begin
            input_word_bus_o <= wr_data_i;
            wr_gap <= 8'(EDGE_GAP_CYC);
            wr_st <= HS_RAISE;
          end
        end
        HS_RAISE: begin
          // data set up first, then rising edge
          // RULE_11: capture on rising strobe
          if (wr_gap == CNT_ZERO) begin
            shift_in_o <= 1'b1;
            wr_st <= HS_WAIT_ACK;
          end
        end
        HS_WAIT_ACK: begin
          // RULE_13: lower only after ready falls
          if (!ir_s2) begin
            shift_in_o <= 1'b0;
            wr_gap <= 8'(EDGE_GAP_CYC);
            wr_st <= HS_LOWER;
          end
        end
        HS_LOWER: begin
          // hold data past the fall, then return
          if (wr_gap == CNT_ZERO) begin
            wr_st <= HS_IDLE;
          end
        end
        default: begin
          wr_st <= HS_IDLE;
          shift_in_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // read handshake: shift-out strobe feeding the buffer
  word_buf_if #(.W(WORD_WIDTH)) fill_s ();
  word_buf_if #(.W(WORD_WIDTH)) drain_s ();
  hs_state_t rd_st; // read state
  logic [7:0] rd_gap; // settle time for output bus
  logic [WORD_WIDTH-1:0] rd_word; // word captured for buffer
  logic rd_push; // word waiting for buffer
  assign fill_s.valid = rd_push;
  assign fill_s.data = rd_word;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_st <= HS_IDLE;
      shift_out_o <= 1'b0;
      rd_gap <= CNT_ZERO;
      rd_word <= '0;
      rd_push <= 1'b0;
    end else begin
      if (rd_gap != CNT_ZERO) begin
        rd_gap <= rd_gap - 8'd1;
      end
      if (rd_push && fill_s.ready) begin
        rd_push <= 1'b0;
      end
      case (rd_st)
        HS_IDLE: begin
          // RULE_23: strobe only while output ready high
          // settle wait covers the bus lagging the flag
          if (init_done && or_s2 && !rd_push) begin
            rd_gap <= 8'(EDGE_GAP_CYC);
            rd_st <= HS_RAISE;
          end
        end
        HS_RAISE: begin
          // RULE_16: take word that the flag vouches for
          if (rd_gap == CNT_ZERO) begin
            rd_word <= ob_s2;
            shift_out_o <= 1'b1;
            rd_st <= HS_WAIT_ACK;
          end
        end
        HS_WAIT_ACK: begin
          // RULE_17: lower after output ready acknowledges
          if (!or_s2) begin
            shift_out_o <= 1'b0;
            rd_push <= 1'b1;
            rd_gap <= 8'(EDGE_GAP_CYC);
            rd_st <= HS_LOWER;
          end
        end
        HS_LOWER: begin
          // RULE_19: wait before looking for next word
          if (rd_gap == CNT_ZERO) begin
            rd_st <= HS_IDLE;
          end
        end
        default: begin
          rd_st <= HS_IDLE;
          shift_out_o <= 1'b0;
        end
      endcase
    end
  end

  // buffer stalls the reader, never loses a word
  word_skid_buf #(.W(WORD_WIDTH)) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // ==========================================================
  // registered consumer output stage
  assign drain_s.ready = !rd_valid_o || rd_ready_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end else if (drain_s.ready) begin
      rd_valid_o <= drain_s.valid;
      rd_data_o <= drain_s.data;
    end
  end
endmodule
`default_nettype wire

/* File: verif/fifo_dev_model.sv */
// behavioural model of the clockless 64-word handshake fifo
`timescale 1ns/1ps
`default_nettype none
module fifo_dev_model #(
  parameter int W = 4,
  parameter int N = 64
) (
  // input side
  input wire logic master_clear_n_i,
  input wire logic shift_in_i,
  input wire logic [W-1:0] input_word_bus_i,
  output var logic input_ready_flag_o,
  // output side
  input wire logic shift_out_i,
  output var logic output_ready_flag_o,
  output var logic [W-1:0] output_word_bus_o
);
  // ==============================
  // storage, head is the output stage
  logic [W-1:0] q[$];
  logic [W-1:0] stage; // input stage word
  logic held = 1'b0; // input stage full
  logic acked = 1'b0; // output word acknowledged
  initial begin
    input_ready_flag_o = 1'b0;
    output_ready_flag_o = 1'b0;
    output_word_bus_o = '0;
  end
  // clear empties every stage
  always @(negedge master_clear_n_i) begin
    q.delete();
    {held, acked, input_ready_flag_o, output_ready_flag_o} = '0;
  end
  always @(posedge shift_in_i) begin
    if (input_ready_flag_o && master_clear_n_i) begin
      stage = input_word_bus_i;
      held = 1'b1;
      #40 input_ready_flag_o = 1'b0;
    end
  end
  always @(negedge shift_in_i) begin
    if (held) begin
      q.push_back(stage);
      held = 1'b0;
    end
  end
  // acknowledge, then release head on fall
  always @(posedge shift_out_i) begin
    if (output_ready_flag_o) begin
      acked = 1'b1;
      #40 output_ready_flag_o = 1'b0;
    end
  end
  always @(negedge shift_out_i) begin
    if (acked) begin
      q.delete(0);
      acked = 1'b0;
    end
  end
  // polling stands in for ripple delay
  always begin
    #7;
    if (master_clear_n_i && !input_ready_flag_o && !shift_in_i && !held && q.size() < N)
      input_ready_flag_o = 1'b1;
    if (master_clear_n_i && !output_ready_flag_o && !acked && q.size() > 0) begin
      output_word_bus_o = q[0];
      #20 output_ready_flag_o = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verif/fifo_host_ctl_asserts.sv */
// concurrent checks on the fifo pins of the host controller
`timescale 1ns/1ps
`default_nettype none
module fifo_host_ctl_asserts #(
  parameter int WORD_WIDTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fifo pins and status
  input wire logic master_clear_n_o,
  input wire logic shift_in_o,
  input wire logic [WORD_WIDTH-1:0] input_word_bus_o,
  input wire logic input_ready_flag_i,
  input wire logic shift_out_o,
  input wire logic output_ready_flag_i,
  input wire logic init_done_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==============================
  // clear pulse and init
  property p_clear_len;
    $fell(rst_i) |-> !master_clear_n_o [*8];
  endproperty
  a_clear_len: assert property (p_clear_len)
    else $error("clear pulse too short");
  property p_quiet;
    !init_done_o |-> !shift_in_o && !shift_out_o;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("strobe before init");
  // ==============================
  // input handshake
  property p_si_rise;
    $rose(shift_in_o) |-> $past(input_ready_flag_i);
  endproperty
  a_si_rise: assert property (p_si_rise)
    else $error("shift in without ready");
  property p_si_hold;
    shift_in_o && input_ready_flag_i |=> shift_in_o;
  endproperty
  a_si_hold: assert property (p_si_hold)
    else $error("shift in dropped early");
  property p_si_drop;
    $fell(input_ready_flag_i) && shift_in_o |-> ##[1:4] !shift_in_o;
  endproperty
  a_si_drop: assert property (p_si_drop)
    else $error("shift in stuck high");
  property p_bus_hold;
    shift_in_o |-> $stable(input_word_bus_o);
  endproperty
  a_bus_hold: assert property (p_bus_hold)
    else $error("input word moved");
  // ==============================
  // output handshake
  property p_so_rise;
    $rose(shift_out_o) |-> $past(output_ready_flag_i);
  endproperty
  a_so_rise: assert property (p_so_rise)
    else $error("shift out without ready");
  property p_so_drop;
    $fell(output_ready_flag_i) && shift_out_o |-> ##[1:4] !shift_out_o;
  endproperty
  a_so_drop: assert property (p_so_drop)
    else $error("shift out stuck high");
endmodule
bind fifo_host_ctl fifo_host_ctl_asserts #(.WORD_WIDTH(WORD_WIDTH)) u_chk (
  .clk_i, .rst_i, .master_clear_n_o, .shift_in_o, .input_word_bus_o,
  .input_ready_flag_i, .shift_out_o, .output_ready_flag_i, .init_done_o);
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the fifo host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fifo_ctl_pkg::*;
  // ==============================
  // clock, reset, wiring
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr_valid_i = 1'b0;
  logic rd_ready_i = 1'b0;
  logic [WORD_W-1:0] wr_data_i = '0;
  logic wr_ready_o, rd_valid_o, master_clear_n_o, shift_in_o, input_ready_flag_i;
  logic shift_out_o, output_ready_flag_i, init_done_o;
  logic [WORD_W-1:0] rd_data_o, input_word_bus_o, output_word_bus_i;
  int miscompares = 0;
  int n_checks = 0;
  always #5 clk_i = ~clk_i;
  fifo_host_ctl i_fifo_host_ctl (.clk_i, .rst_i, .wr_valid_i, .wr_data_i, .wr_ready_o,
    .rd_valid_o, .rd_data_o, .rd_ready_i, .master_clear_n_o, .shift_in_o,
    .input_word_bus_o, .input_ready_flag_i, .shift_out_o, .output_ready_flag_i,
    .output_word_bus_i, .init_done_o);
  fifo_dev_model #(.W(WORD_W), .N(DEPTH)) u_dev (.master_clear_n_i(master_clear_n_o),
    .shift_in_i(shift_in_o), .input_word_bus_i(input_word_bus_o),
    .input_ready_flag_o(input_ready_flag_i), .shift_out_i(shift_out_o),
    .output_ready_flag_o(output_ready_flag_i), .output_word_bus_o(output_word_bus_i));
  // ==============================
  // shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // offer one word; valid stays up, caller lowers it
  task automatic put(input logic [WORD_W-1:0] w, output bit ok);
    int n;
    n = 0;
    wr_valid_i = 1'b1;
    wr_data_i = w;
    while (wr_ready_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    ok = (wr_ready_o === 1'b1);
    @(negedge clk_i);
  endtask
  // take one word and compare it
  task automatic get(input logic [WORD_W-1:0] exp);
    int n;
    n = 0;
    rd_ready_i = 1'b1;
    while (rd_valid_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    check(8'({rd_valid_o, rd_data_o}), 8'({1'b1, exp}));
    @(negedge clk_i);
  endtask
  // ==============================
  // scenarios
  task automatic t_reset();
    repeat (5) @(negedge clk_i);
    check(8'(master_clear_n_o), 8'h00);
    rst_i = 1'b0;
    repeat (30) @(negedge clk_i);
    check(8'({init_done_o, master_clear_n_o, input_ready_flag_i}), 8'h07);
    check(8'(output_ready_flag_i), 8'h00);
    $display("test reset done");
  endtask
  task automatic t_single();
    bit ok;
    put(4'ha, ok);
    wr_valid_i = 1'b0;
    check(8'(ok), 8'h01);
    get(4'ha);
    rd_ready_i = 1'b0;
    repeat (40) @(negedge clk_i);
    check(8'({rd_valid_o, output_ready_flag_i, output_word_bus_i}), 8'h0a);
    $display("test single done");
  endtask
  task automatic t_fill();
    bit ok;
    int i;
    ok = 1'b1;
    for (i = 0; i < 80 && ok; i++) put(i[3:0], ok);
    wr_valid_i = 1'b0;
    check(8'({ok, input_ready_flag_i}), 8'h00);
    check(8'(u_dev.q.size()), 8'(DEPTH));
    // controller absorbs four words: output stage, two buffer slots, one pending
    check(8'(i - 1), 8'(DEPTH + 4));
    for (int k = 0; k < i - 1; k++) get(k[3:0]);
    rd_ready_i = 1'b0;
    check(8'({rd_valid_o, output_ready_flag_i}), 8'h00);
    $display("test fill and drain done");
  endtask
  // watchdog, well past the expected few thousand cycles
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
  initial begin
    t_reset();
    t_single();
    t_fill();
    stop_test();
  end
endmodule
`default_nettype wire
